// ===== accel_power_domain_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module accel_power_domain_ctrl_test;
  import apdc_pkg::*;
  // ==========================================================
  // signals
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic soft_reset = 1'b0;
  logic periph_reset = 1'b0;
  logic deep_mode = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic clock_en = 1'b1;
  logic hresp;
  logic hreadyout;
  logic [3:0] supply_pin, ram_pin, iso, dom_rst, logic_up, ram_up;
  int fail_count = 0;
  int checked = 0;
  always #2.5 clock = ~clock;
  apdc_top apdc_top_inst (.i_clock(clock), .i_reset(reset), .i_clock_en(clock_en),
    .i_soft_reset(soft_reset), .i_periph_reset(periph_reset), .i_deep_mode(deep_mode),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .o_supply_pin(supply_pin), .o_ram_pin(ram_pin),
    .o_iso(iso), .o_dom_rst(dom_rst));
  apdc_switch_model apdc_switch_model_inst (.i_clock(clock), .i_supply_pin(supply_pin),
    .i_ram_pin(ram_pin), .o_logic_up(logic_up), .o_ram_up(ram_up));
  // ==========================================================
  // reporting
  task automatic test_done();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========================================================
  // bus master: never assumes a latency, waits under a bound
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        $display("wrong value hreadyout expected 1 seen %b", hreadyout);
        test_done();
      end
      @(posedge clock);
    end
  endtask
  task automatic bus_access(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= APDC_HTRANS_NONSEQ;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    check("hresp", {31'h0, APDC_HRESP_OKAY}, {31'h0, hresp});
  endtask
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus_access(1'b1, a, d, unused);
  endtask
  task automatic read_check(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus_access(1'b0, a, 32'h0, rd);
    check(what, exp, rd);
  endtask
  task automatic pins_check(input logic [3:0] sp, input logic [3:0] rp);
    repeat (3) @(posedge clock);
    check("supply pin", {28'h0, sp}, {28'h0, supply_pin});
    check("ram pin", {28'h0, rp}, {28'h0, ram_pin});
    check("switch logic", {28'h0, sp}, {28'h0, logic_up});
    check("switch ram", {28'h0, rp}, {28'h0, ram_up});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    for (int i = 0; i < 4; i++) begin
      read_check("reset value", 32'(i * 4), APDC_WORD_ZERO);
    end
    pins_check(4'h0, 4'h0);
  endtask
  task automatic t_field_masks();
    for (int i = 0; i < 4; i++) begin
      bus_write(32'(i * 4), 32'hffff_ffff);
    end
    read_check("power reg", 32'h0, 32'h0000_000f);
    read_check("ram reg", 32'h4, 32'h0000_000f);
    read_check("retention reg", 32'h8, 32'h00ff_000f);
    read_check("domain reset reg", 32'hc, 32'h0000_000f);
    pins_check(4'hf, 4'hf);
    check("iso pin", 32'hf, {28'h0, iso});
    check("domain reset pin", 32'hf, {28'h0, dom_rst});
    for (int i = 0; i < 4; i++) begin
      bus_write(32'(i * 4), 32'h0);
    end
  endtask
  task automatic t_deep_mode();
    bus_write(32'h0, 32'h3);
    bus_write(32'h4, 32'hf);
    bus_write(32'h8, 32'h0096_0000);
    pins_check(4'h3, 4'hf);
    deep_mode <= 1'b1;
    pins_check(4'h6, 4'h9);
    read_check("ram reg deep", 32'h4, 32'h0);
    bus_write(32'h4, 32'h5);
    read_check("ram reg deep write", 32'h4, 32'h0);
    deep_mode <= 1'b0;
    pins_check(4'h3, 4'h0);
  endtask
  task automatic t_unmapped();
    bus_write(32'h10, 32'hffff_ffff);
    bus_write(32'h1, 32'hffff_ffff);
    read_check("unmapped read", 32'h10, 32'h0);
    read_check("power reg kept", 32'h0, 32'h3);
    read_check("ram reg kept", 32'h4, 32'h0);
  endtask
  task automatic t_resets();
    for (int k = 0; k < 3; k++) begin
      bus_write(32'hc, 32'h5);
      bus_write(32'h0, 32'ha);
      repeat (3) @(posedge clock);
      check("domain reset pin", 32'h5, {28'h0, dom_rst});
      if (k == 0) reset <= 1'b1;
      if (k == 1) soft_reset <= 1'b1;
      if (k == 2) periph_reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      soft_reset <= 1'b0;
      periph_reset <= 1'b0;
      read_check("domain reset after reset", 32'hc, 32'h0);
      read_check("power after reset", 32'h0, 32'h0);
      pins_check(4'h0, 4'h0);
      check("domain reset pin cleared", 32'h0, {28'h0, dom_rst});
    end
  endtask
  // ==========================================================
  // clock enable low freezes pins even when the mode changes
  task automatic t_clock_hold();
    bus_write(32'h0, 32'h5);
    bus_write(32'h8, 32'h00a0_0000);
    pins_check(4'h5, 4'h0);
    clock_en <= 1'b0;
    deep_mode <= 1'b1;
    pins_check(4'h5, 4'h0);
    clock_en <= 1'b1;
    pins_check(4'h0, 4'ha);
    deep_mode <= 1'b0;
    pins_check(4'h5, 4'h0);
    read_check("power after hold", 32'h0, 32'h5);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_reset_values();
    t_field_masks();
    t_deep_mode();
    t_unmapped();
    t_resets();
    t_clock_hold();
    test_done();
  end
endmodule
`default_nettype wire

// ===== apdc_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface apdc_ctrl_if;
  logic [3:0] pwr_en;
  logic [3:0] ram_en;
  logic [3:0] ram_ret;
  logic [3:0] logic_ret;
  logic [3:0] iso;
  logic [3:0] dom_rst;
  logic deep;
  modport regs (output pwr_en, ram_en, ram_ret, logic_ret, iso, dom_rst, deep);
  modport drive (input pwr_en, ram_en, ram_ret, logic_ret, iso, dom_rst, deep);
endinterface
`default_nettype wire

// ===== apdc_pin_drive.sv
`timescale 1ns/1ps
`default_nettype none
module apdc_pin_drive (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_en,
  apdc_ctrl_if.drive ctrl,
  output logic [3:0] o_supply_pin,
  output logic [3:0] o_ram_pin,
  output logic [3:0] o_iso,
  output logic [3:0] o_dom_rst
);
  import apdc_pkg::*;
  logic [3:0] supply_d;
  logic [3:0] ram_d;
  // ==========================================================
  // per quadrant pin selection
  genvar q;
  generate
    for (q = 0; q < APDC_QUADS; q++) begin : g_quad
      always_comb begin
        supply_d[q] = ctrl.deep ? ctrl.logic_ret[q] : ctrl.pwr_en[q];
        ram_d[q] = ctrl.deep ? ctrl.ram_ret[q] : ctrl.ram_en[q];
      end
    end
  endgenerate
  // pins are registered so the switches never see decode glitches
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_supply_pin <= APDC_FIELD_RST;
      o_ram_pin <= APDC_FIELD_RST;
      o_iso <= APDC_FIELD_RST;
      o_dom_rst <= APDC_FIELD_RST;
    end else if (i_clock_en) begin
      o_supply_pin <= supply_d;
      o_ram_pin <= ram_d;
      o_iso <= ctrl.iso;
      o_dom_rst <= ctrl.dom_rst;
    end
  end
  // ==========================================================
  // checks
  property p_supply_deep;
    @(posedge i_clock) disable iff (i_reset)
    (!i_reset && i_clock_en && ctrl.deep) |=> (o_supply_pin == $past(ctrl.logic_ret));
  endproperty
  a_supply_deep: assert property (p_supply_deep) else $error("deep supply pin mismatch");
  property p_supply_run;
    @(posedge i_clock) disable iff (i_reset)
    (!i_reset && i_clock_en && !ctrl.deep) |=> (o_supply_pin == $past(ctrl.pwr_en));
  endproperty
  a_supply_run: assert property (p_supply_run) else $error("run supply pin mismatch");
  property p_ram_deep;
    @(posedge i_clock) disable iff (i_reset)
    (!i_reset && i_clock_en && ctrl.deep) |=> (o_ram_pin == $past(ctrl.ram_ret));
  endproperty
  a_ram_deep: assert property (p_ram_deep) else $error("deep ram pin mismatch");
  property p_ram_run;
    @(posedge i_clock) disable iff (i_reset)
    (!i_reset && i_clock_en && !ctrl.deep) |=> (o_ram_pin == $past(ctrl.ram_en));
  endproperty
  a_ram_run: assert property (p_ram_run) else $error("run ram pin mismatch");
endmodule
`default_nettype wire

// ===== apdc_pkg.sv
// Function
// - system, soft and peripheral resets return every field to reset.
// - four word registers decoded at offsets 0x0 through 0xc.
// - register 0 bits 3:0 enable quadrant supply pins in run modes.
// - in deep modes supply pins follow the logic retention switch bits.
// - register 1 bits 3:0 set quadrant ram supply pins in run modes.
// - deep modes force every ram supply enable bit to zero.
// - deep modes take ram keep-alive from register 2 retention bits.
// - register 2 bits 23:20 ram retention, 19:16 logic retention, reset 0.
// - register 2 bits 3:0 isolate each quadrant domain, reset 0.
// - register 3 bits 3:0 start a quadrant domain reset when 1.
package apdc_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] APDC_OFS_PWR = 4'h0;
  localparam logic [3:0] APDC_OFS_RAM = 4'h4;
  localparam logic [3:0] APDC_OFS_RET = 4'h8;
  localparam logic [3:0] APDC_OFS_RST = 4'hc;
  localparam int APDC_ADDR_W = 4;
  localparam int APDC_QUADS = 4;
  // ==========================================================
  // field positions
  localparam int APDC_RAMRET_LSB = 20;
  localparam int APDC_LOGRET_LSB = 16;
  localparam int APDC_ISO_LSB = 0;
  localparam int APDC_LOW_LSB = 0;
  // ==========================================================
  // reset values
  localparam logic [3:0] APDC_FIELD_RST = 4'h0;
  localparam logic [31:0] APDC_WORD_ZERO = 32'h0000_0000;
  // ==========================================================
  // bus encodings
  localparam logic [1:0] APDC_HTRANS_NONSEQ = 2'h2;
  localparam logic APDC_HRESP_OKAY = 1'b0;
endpackage

// ===== apdc_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external supply switches: one cycle to settle after a pin moves
module apdc_switch_model (
  input wire logic i_clock,
  input wire logic [3:0] i_supply_pin,
  input wire logic [3:0] i_ram_pin,
  output logic [3:0] o_logic_up,
  output logic [3:0] o_ram_up
);
  always_ff @(posedge i_clock) begin
    o_logic_up <= i_supply_pin;
    o_ram_up <= i_ram_pin;
  end
endmodule
`default_nettype wire

// ===== apdc_top.sv
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module apdc_top (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_en,
  input wire logic i_soft_reset,
  input wire logic i_periph_reset,
  input wire logic i_deep_mode,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [apdc_pkg::APDC_QUADS-1:0] o_supply_pin,
  output logic [apdc_pkg::APDC_QUADS-1:0] o_ram_pin,
  output logic [apdc_pkg::APDC_QUADS-1:0] o_iso,
  output logic [apdc_pkg::APDC_QUADS-1:0] o_dom_rst
);
  import apdc_pkg::*;
  apdc_ctrl_if ctrl ();
  logic any_reset;
  logic [3:0] pwr_q, pwr_d;
  logic [3:0] ram_q, ram_d;
  logic [3:0] ramret_q, ramret_d;
  logic [3:0] logret_q, logret_d;
  logic [3:0] iso_q, iso_d;
  logic [3:0] rst_q, rst_d;
  logic wr_pend_q, wr_pend_d;
  logic [3:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic addr_phase;

  assign any_reset = i_reset | i_soft_reset | i_periph_reset;
  assign addr_phase = i_hsel && i_hready && (i_htrans == APDC_HTRANS_NONSEQ);

  // ==========================================================
  // decode helpers
  // word offsets 0x0 to 0xc
  function automatic logic hits(input logic [31:0] addr, input logic [3:0] ofs);
    hits = (addr[31:APDC_ADDR_W] == 28'h0000000) && (addr[APDC_ADDR_W-1:0] == ofs);
  endfunction

  function automatic logic [31:0] read_word(input logic [3:0] ofs, input logic [3:0] p,
      input logic [3:0] r, input logic [3:0] rr, input logic [3:0] lr,
      input logic [3:0] io, input logic [3:0] dr);
    logic [31:0] w;
    w = APDC_WORD_ZERO;
    case (ofs)
      APDC_OFS_PWR: w[APDC_LOW_LSB +: 4] = p;
      APDC_OFS_RAM: w[APDC_LOW_LSB +: 4] = r;
      APDC_OFS_RET: begin
        w[APDC_RAMRET_LSB +: 4] = rr;
        w[APDC_LOGRET_LSB +: 4] = lr;
        w[APDC_ISO_LSB +: 4] = io;
      end
      APDC_OFS_RST: w[APDC_LOW_LSB +: 4] = dr;
      default: w = APDC_WORD_ZERO;
    endcase
    read_word = w;
  endfunction

  // ==========================================================
  // bus slave
  always_comb begin
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    pwr_d = pwr_q;
    ram_d = ram_q;
    ramret_d = ramret_q;
    logret_d = logret_q;
    iso_d = iso_q;
    rst_d = rst_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        APDC_OFS_PWR: pwr_d = i_hwdata[APDC_LOW_LSB +: 4];
        APDC_OFS_RAM: ram_d = i_hwdata[APDC_LOW_LSB +: 4];
        APDC_OFS_RET: begin
          ramret_d = i_hwdata[APDC_RAMRET_LSB +: 4];
          logret_d = i_hwdata[APDC_LOGRET_LSB +: 4];
          iso_d = i_hwdata[APDC_ISO_LSB +: 4];
        end
        APDC_OFS_RST: rst_d = i_hwdata[APDC_LOW_LSB +: 4];
        default: rst_d = rst_q;
      endcase
    end
    if (i_deep_mode) begin
      ram_d = APDC_FIELD_RST;
    end
    rdata_d = rdata_q;
    if (addr_phase) begin
      wr_pend_d = i_hwrite && (hits(i_haddr, APDC_OFS_PWR) || hits(i_haddr, APDC_OFS_RAM)
          || hits(i_haddr, APDC_OFS_RET) || hits(i_haddr, APDC_OFS_RST));
      wr_addr_d = i_haddr[APDC_ADDR_W-1:0];
      // reads use next values so a read right after a write sees it
      if (!i_hwrite && i_haddr[31:APDC_ADDR_W] == 28'h0000000) begin
        rdata_d = read_word(i_haddr[APDC_ADDR_W-1:0], pwr_d, ram_d, ramret_d, logret_d,
            iso_d, rst_d);
      end else begin
        rdata_d = APDC_WORD_ZERO;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (any_reset) begin
      pwr_q <= APDC_FIELD_RST;
      ram_q <= APDC_FIELD_RST;
      ramret_q <= APDC_FIELD_RST;
      logret_q <= APDC_FIELD_RST;
      iso_q <= APDC_FIELD_RST;
      rst_q <= APDC_FIELD_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= APDC_OFS_PWR;
      rdata_q <= APDC_WORD_ZERO;
      o_hreadyout <= 1'b1;
      o_hresp <= APDC_HRESP_OKAY;
    end else if (i_clock_en) begin
      pwr_q <= pwr_d;
      ram_q <= ram_d;
      ramret_q <= ramret_d;
      logret_q <= logret_d;
      iso_q <= iso_d;
      rst_q <= rst_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      o_hreadyout <= 1'b1;
      o_hresp <= APDC_HRESP_OKAY;
    end
  end
  assign o_hrdata = rdata_q;

  // ==========================================================
  // pin drive
  assign ctrl.pwr_en = pwr_q;
  assign ctrl.ram_en = ram_q;
  assign ctrl.ram_ret = ramret_q;
  assign ctrl.logic_ret = logret_q;
  assign ctrl.iso = iso_q;
  assign ctrl.dom_rst = rst_q;
  assign ctrl.deep = i_deep_mode;

  apdc_pin_drive u_drive (
    .i_clock(i_clock),
    .i_reset(any_reset),
    .i_clock_en(i_clock_en),
    .ctrl(ctrl.drive),
    .o_supply_pin(o_supply_pin),
    .o_ram_pin(o_ram_pin),
    .o_iso(o_iso),
    .o_dom_rst(o_dom_rst)
  );

  // ==========================================================
  // checks
  property p_soft_clear;
    @(posedge i_clock) (i_soft_reset || i_periph_reset) |=> (pwr_q == 4'h0 && ramret_q == 4'h0
        && iso_q == 4'h0 && rst_q == 4'h0);
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("reset did not clear fields");
  property p_deep_ram;
    @(posedge i_clock) disable iff (any_reset)
    (i_clock_en && i_deep_mode) |=> (ram_q == 4'h0);
  endproperty
  a_deep_ram: assert property (p_deep_ram) else $error("ram enables not forced low");
  property p_pwr_write;
    @(posedge i_clock) disable iff (any_reset)
    (i_clock_en && addr_phase && i_hwrite && hits(i_haddr, APDC_OFS_PWR)) ##1 i_clock_en
        |=> (pwr_q == $past(i_hwdata[3:0]));
  endproperty
  a_pwr_write: assert property (p_pwr_write) else $error("supply enable write lost");
  property p_ret_read;
    @(posedge i_clock) disable iff (any_reset)
    (i_clock_en && addr_phase && !i_hwrite && hits(i_haddr, APDC_OFS_RET) && !wr_pend_q)
        |=> (o_hrdata == {8'h00, ramret_q, logret_q, 12'h000, iso_q});
  endproperty
  a_ret_read: assert property (p_ret_read) else $error("register 2 read mismatch");
  property p_low_read;
    @(posedge i_clock) disable iff (any_reset)
    (i_clock_en && addr_phase && !i_hwrite && hits(i_haddr, APDC_OFS_RAM) && !wr_pend_q
        && !i_deep_mode) |=> (o_hrdata[31:4] == 28'h0000000 && o_hrdata[3:0] == ram_q);
  endproperty
  a_low_read: assert property (p_low_read) else $error("register 1 read mismatch");
  property p_ready;
    @(posedge i_clock) disable iff (any_reset) i_clock_en |=> (o_hreadyout && o_hresp == 1'b0);
  endproperty
  a_ready: assert property (p_ready) else $error("slave not ready with okay");
  property p_rst_pin;
    @(posedge i_clock) disable iff (any_reset)
    (i_clock_en && $rose(rst_q[0])) |=> (o_dom_rst[0] || !i_clock_en);
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("domain reset pin late");
  property p_iso_pin;
    @(posedge i_clock) disable iff (any_reset)
    (!any_reset && i_clock_en) |=> (o_iso == $past(iso_q));
  endproperty
  a_iso_pin: assert property (p_iso_pin) else $error("isolation pin mismatch");
  property p_dom_rst_pin;
    @(posedge i_clock) disable iff (any_reset)
    (!any_reset && i_clock_en) |=> (o_dom_rst == $past(rst_q));
  endproperty
  a_dom_rst_pin: assert property (p_dom_rst_pin) else $error("domain reset pin lag");
  // the enable freezes every register, bus included
  property p_hold_state;
    @(posedge i_clock) disable iff (any_reset)
    (!any_reset && !i_clock_en) |=> ($stable(pwr_q) && $stable(ram_q) && $stable(o_hrdata));
  endproperty
  a_hold_state: assert property (p_hold_state) else $error("state moved while frozen");
endmodule
`default_nettype wire
